// file: src/eps_stats_consts.vh
// register map, field positions and constants for the port statistics block
`ifndef EPS_STATS_CONSTS_VH
`define EPS_STATS_CONSTS_VH

// counter width and thresholds
`define EPS_CNT_W 32
`define EPS_HALF_SCALE 32'h8000_0000
`define EPS_CNT_ZERO 32'h0000_0000
`define EPS_MIN_FRAME_LEN 16'h0040
`define EPS_PAUSE_TYPE 16'h8808
`define EPS_PAUSE_OPCODE 16'h0001

// counter indices (byte address = index * 4)
`define EPS_IDX_RX_GOOD 4'h0
`define EPS_IDX_RX_BCAST 4'h1
`define EPS_IDX_RX_MCAST 4'h2
`define EPS_IDX_RX_PAUSE 4'h3
`define EPS_IDX_RX_CRC 4'h4
`define EPS_IDX_RX_ALIGN 4'h5
`define EPS_IDX_RX_OVER 4'h6
`define EPS_IDX_RX_JABBER 4'h7
`define EPS_IDX_RX_UNDER 4'h8
`define EPS_IDX_RX_FRAG 4'h9
`define EPS_IDX_RX_OCTETS 4'hA
`define EPS_IDX_TX_GOOD 4'hB
`define EPS_IDX_TX_BCAST 4'hC
`define EPS_IDX_TX_MCAST 4'hD
`define EPS_NUM_CNT 14

// control and interrupt registers
`define EPS_ADDR_IRQ_STATUS 8'h40
`define EPS_ADDR_IRQ_MASK 8'h44
`define EPS_ADDR_CONTROL 8'h48
`define EPS_ADDR_LEVEL 8'h4C

// control register fields
`define EPS_CTL_FLOW_EN 0
`define EPS_CTL_MAXLEN_LSB 16
`define EPS_CTL_MAXLEN_MSB 31
`define EPS_CTL_RESET 32'h05EE_0000

// interrupt status bits
`define EPS_IRQ_HALF 0
`define EPS_IRQ_RX_DONE 1
`define EPS_IRQ_TX_DONE 2
`define EPS_IRQ_W 3

`endif

// file: src/eps_port_stats.v
// per-port ethernet frame statistics counters with register port and interrupt
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Overview of operation
// - interrupt when any counter reaches half scale and the half-scale mask bit is set
// - software decrements counters; interrupt then drops
// - 32-bit counters wrap without saturating
// - count good received frames, legal length
// - count good received broadcast frames
// - count good received non-broadcast multicast frames
// - count legal pause frames while flow enabled
// - count matched legal frames with checksum error
// - count odd-nibble checksum failures and code errors
// - receive error during frame marks code error
// - count long matched frames without errors
// - count long matched frames with errors
// - count short matched clean data frames
// - count short errored frames, not flow fragments
// - sum byte lengths of good received frames
// - count good transmitted frames
// - count good transmitted broadcast frames
// - count good transmitted multicast frames
// ----------------------------------------------------------------------------
`include "eps_stats_consts.vh"

module eps_port_stats #(
  parameter CNT_W = 32,
  parameter LEN_W = 16
) (
  input wire core_clk,
  input wire rstn,
  input wire clkEn,
  // register port
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [31:0] regRdData,
  // receive frame status, one pulse per finished frame
  input wire rxDone,
  input wire [LEN_W-1:0] rxLen,
  input wire [47:0] rxDestAddr,
  input wire [15:0] rxTypeField,
  input wire [15:0] rxOpcode,
  input wire rxAddrMatch,
  input wire rxIsControl,
  input wire rxOddNibbles,
  input wire rxFcsFail,
  input wire rxCollFlowFrag,
  // phy receive error pin and frame activity pin
  input wire phyReceiveError,
  input wire phyRxActive,
  // transmit frame status, one pulse per finished frame
  input wire txDone,
  input wire [47:0] txDestAddr,
  input wire txLateColl,
  input wire txExcessColl,
  input wire txCarrierLoss,
  input wire txUnderrun,
  // outputs
  output wire irqOut,
  output reg counterHalfScaleIrq
);

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------
  // all-ones broadcast destination
  function isBcast;
    input [47:0] da;
    begin
      isBcast = &da;
    end
  endfunction

  // multicast bit set, but not broadcast
  function isMcast;
    input [47:0] da;
    begin
      isMcast = da[40] & ~(&da);
    end
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers for phy receive error and activity
  // --------------------------------------------------------------------------
  reg [2:0] rxErrSync_reg; // three-stage sampler
  reg [2:0] rxActSync_reg; // three-stage sampler
  reg rxErrLvl_reg; // agreed level of error pin
  reg rxActLvl_reg; // agreed level of activity pin
  reg codeErrSeen_reg; // error seen during current frame
  reg codeErrFrame_reg; // latched result of last frame

  // sample pins, accept change once stages two and three agree
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      rxErrSync_reg <= 3'h0;
      rxActSync_reg <= 3'h0;
      rxErrLvl_reg <= 1'b0;
      rxActLvl_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      rxErrSync_reg <= {rxErrSync_reg[1:0], phyReceiveError};
      rxActSync_reg <= {rxActSync_reg[1:0], phyRxActive};
      if (rxErrSync_reg[1] == rxErrSync_reg[2])
        rxErrLvl_reg <= rxErrSync_reg[2];
      if (rxActSync_reg[1] == rxActSync_reg[2])
        rxActLvl_reg <= rxActSync_reg[2];
    end
  end

  // track receive error across the frame
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      codeErrSeen_reg <= 1'b0;
      codeErrFrame_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      if (rxErrLvl_reg && rxActLvl_reg)
        codeErrSeen_reg <= 1'b1;
      else if (!rxActLvl_reg && !rxDone)
        codeErrSeen_reg <= 1'b0;
      if (rxDone)
      begin
        codeErrFrame_reg <= codeErrSeen_reg | (rxErrLvl_reg & rxActLvl_reg);
        codeErrSeen_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  reg [31:0] ctl_reg; // flow enable and max length
  reg [`EPS_IRQ_W-1:0] irqStatus_reg; // sticky event bits
  reg [`EPS_IRQ_W-1:0] irqMask_reg; // interrupt enables
  wire flowEn = ctl_reg[`EPS_CTL_FLOW_EN];
  wire [15:0] rxMaxFrameLength = ctl_reg[`EPS_CTL_MAXLEN_MSB:`EPS_CTL_MAXLEN_LSB];

  // --------------------------------------------------------------------------
  // frame classification, registered one cycle after the status pulse
  // --------------------------------------------------------------------------
  reg rxStage_reg; // staged receive frame valid
  reg [LEN_W-1:0] rxLenS_reg;
  reg [47:0] rxDaS_reg;
  reg [15:0] rxTypeS_reg;
  reg [15:0] rxOpS_reg;
  reg rxMatchS_reg;
  reg rxCtlS_reg;
  reg rxOddS_reg;
  reg rxFcsS_reg;
  reg rxCollS_reg;
  reg txStage_reg; // staged transmit frame valid
  reg [47:0] txDaS_reg;
  reg txOkS_reg;

  // capture status so code error of the frame is already settled
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      rxStage_reg <= 1'b0;
      txStage_reg <= 1'b0;
      rxLenS_reg <= {LEN_W{1'b0}};
      rxDaS_reg <= 48'h0000_0000_0000;
      rxTypeS_reg <= 16'h0000;
      rxOpS_reg <= 16'h0000;
      rxMatchS_reg <= 1'b0;
      rxCtlS_reg <= 1'b0;
      rxOddS_reg <= 1'b0;
      rxFcsS_reg <= 1'b0;
      rxCollS_reg <= 1'b0;
      txDaS_reg <= 48'h0000_0000_0000;
      txOkS_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      rxStage_reg <= rxDone;
      txStage_reg <= txDone;
      if (rxDone)
      begin
        rxLenS_reg <= rxLen;
        rxDaS_reg <= rxDestAddr;
        rxTypeS_reg <= rxTypeField;
        rxOpS_reg <= rxOpcode;
        rxMatchS_reg <= rxAddrMatch;
        rxCtlS_reg <= rxIsControl;
        rxOddS_reg <= rxOddNibbles;
        rxFcsS_reg <= rxFcsFail;
        rxCollS_reg <= rxCollFlowFrag;
      end
      if (txDone)
      begin
        txDaS_reg <= txDestAddr;
        txOkS_reg <= ~(txLateColl | txExcessColl | txCarrierLoss | txUnderrun);
      end
    end
  end

  // error and length classes of the staged receive frame
  wire codeErr = codeErrFrame_reg;
  wire crcErr = rxFcsS_reg & ~rxOddS_reg & ~codeErr;
  wire alignErr = rxFcsS_reg & rxOddS_reg & ~codeErr;
  wire anyErr = crcErr | alignErr | codeErr;
  wire lenShort = rxLenS_reg < `EPS_MIN_FRAME_LEN;
  wire lenLong = rxLenS_reg > rxMaxFrameLength;
  wire lenOk = ~lenShort & ~lenLong;
  wire goodRx = rxStage_reg & rxMatchS_reg & lenOk & ~anyErr;
  wire isPause = (rxTypeS_reg == `EPS_PAUSE_TYPE) & (rxOpS_reg == `EPS_PAUSE_OPCODE);
  wire goodTx = txStage_reg & txOkS_reg;

  // increment per counter for this cycle
  reg [CNT_W-1:0] incr [0:`EPS_NUM_CNT-1];
  integer k;
  always @*
  begin
    for (k = 0; k < `EPS_NUM_CNT; k = k + 1)
      incr[k] = {CNT_W{1'b0}};
    incr[`EPS_IDX_RX_GOOD] = {{(CNT_W-1){1'b0}}, goodRx};
    incr[`EPS_IDX_RX_BCAST] = {{(CNT_W-1){1'b0}}, goodRx & isBcast(rxDaS_reg)};
    incr[`EPS_IDX_RX_MCAST] = {{(CNT_W-1){1'b0}}, goodRx & isMcast(rxDaS_reg)};
    incr[`EPS_IDX_RX_PAUSE] = {{(CNT_W-1){1'b0}},
      rxStage_reg & lenOk & ~anyErr & isPause & flowEn};
    incr[`EPS_IDX_RX_CRC] = {{(CNT_W-1){1'b0}}, rxStage_reg & rxMatchS_reg & lenOk & crcErr};
    incr[`EPS_IDX_RX_ALIGN] = {{(CNT_W-1){1'b0}},
      rxStage_reg & rxMatchS_reg & lenOk & (alignErr | codeErr)};
    incr[`EPS_IDX_RX_OVER] = {{(CNT_W-1){1'b0}}, rxStage_reg & rxMatchS_reg & lenLong & ~anyErr};
    incr[`EPS_IDX_RX_JABBER] = {{(CNT_W-1){1'b0}}, rxStage_reg & rxMatchS_reg & lenLong & anyErr};
    incr[`EPS_IDX_RX_UNDER] = {{(CNT_W-1){1'b0}},
      rxStage_reg & rxMatchS_reg & ~rxCtlS_reg & lenShort & ~anyErr};
    incr[`EPS_IDX_RX_FRAG] = {{(CNT_W-1){1'b0}},
      rxStage_reg & ~rxCtlS_reg & lenShort & anyErr & ~rxCollS_reg};
    if (goodRx)
      incr[`EPS_IDX_RX_OCTETS] = {{(CNT_W-LEN_W){1'b0}}, rxLenS_reg};
    incr[`EPS_IDX_TX_GOOD] = {{(CNT_W-1){1'b0}}, goodTx};
    incr[`EPS_IDX_TX_BCAST] = {{(CNT_W-1){1'b0}}, goodTx & isBcast(txDaS_reg)};
    incr[`EPS_IDX_TX_MCAST] = {{(CNT_W-1){1'b0}}, goodTx & isMcast(txDaS_reg)};
  end

  // --------------------------------------------------------------------------
  // counter storage
  // --------------------------------------------------------------------------
  reg [CNT_W-1:0] cnt_reg [0:`EPS_NUM_CNT-1];
  wire wrCnt = regWrStb & (regAddr[1:0] == 2'b00) & (regAddr[7:6] == 2'b00)
    & (regAddr[5:2] < `EPS_NUM_CNT);
  wire [3:0] wrIdx = regAddr[5:2];

  // add frame increment, subtract software write, wrap freely
  integer i;
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      for (i = 0; i < `EPS_NUM_CNT; i = i + 1)
        cnt_reg[i] <= {CNT_W{1'b0}};
    end
    else if (clkEn)
    begin
      for (i = 0; i < `EPS_NUM_CNT; i = i + 1)
      begin
        if (wrCnt && (wrIdx == i[3:0]))
          cnt_reg[i] <= cnt_reg[i] + incr[i] - regWrData[CNT_W-1:0];
        else
          cnt_reg[i] <= cnt_reg[i] + incr[i];
      end
    end
  end

  // any counter at or above half scale
  reg halfAny;
  integer j;
  always @*
  begin
    halfAny = 1'b0;
    for (j = 0; j < `EPS_NUM_CNT; j = j + 1)
      halfAny = halfAny | cnt_reg[j][CNT_W-1];
  end

  // --------------------------------------------------------------------------
  // control, interrupt status and mask
  // --------------------------------------------------------------------------
  wire [`EPS_IRQ_W-1:0] irqEvents = {txStage_reg, rxStage_reg, halfAny};

  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ctl_reg <= `EPS_CTL_RESET;
      irqStatus_reg <= {`EPS_IRQ_W{1'b0}};
      irqMask_reg <= {`EPS_IRQ_W{1'b0}};
      counterHalfScaleIrq <= 1'b0;
    end
    else if (clkEn)
    begin
      if (regWrStb && regAddr == `EPS_ADDR_CONTROL)
        ctl_reg <= regWrData;
      if (regWrStb && regAddr == `EPS_ADDR_IRQ_MASK)
        irqMask_reg <= regWrData[`EPS_IRQ_W-1:0];
      // set wins over write-one-to-clear
      if (regWrStb && regAddr == `EPS_ADDR_IRQ_STATUS)
        irqStatus_reg <= (irqStatus_reg & ~regWrData[`EPS_IRQ_W-1:0]) | irqEvents;
      else
        irqStatus_reg <= irqStatus_reg | irqEvents;
      // registered level of any counter at half scale, gated by the half-scale mask bit
      counterHalfScaleIrq <= halfAny & irqMask_reg[`EPS_IRQ_HALF];
    end
  end

  // half-scale bit is a level, event bits are sticky
  wire [`EPS_IRQ_W-1:0] irqView = {irqStatus_reg[`EPS_IRQ_TX_DONE:`EPS_IRQ_RX_DONE], halfAny};
  assign irqOut = |(irqView & irqMask_reg);

  // --------------------------------------------------------------------------
  // read port, data valid one cycle after the strobe
  // --------------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!rstn)
      regRdData <= 32'h0000_0000;
    else if (clkEn)
    begin
      if (!regRdStb)
        regRdData <= 32'h0000_0000;
      else if (regAddr[7:6] == 2'b00 && regAddr[1:0] == 2'b00 && regAddr[5:2] < `EPS_NUM_CNT)
        regRdData <= cnt_reg[regAddr[5:2]];
      else if (regAddr == `EPS_ADDR_IRQ_STATUS)
        regRdData <= {{(32-`EPS_IRQ_W){1'b0}}, irqView};
      else if (regAddr == `EPS_ADDR_IRQ_MASK)
        regRdData <= {{(32-`EPS_IRQ_W){1'b0}}, irqMask_reg};
      else if (regAddr == `EPS_ADDR_CONTROL)
        regRdData <= ctl_reg;
      else if (regAddr == `EPS_ADDR_LEVEL)
        regRdData <= {31'h0000_0000, halfAny};
      else
        regRdData <= 32'h0000_0000; // unmapped reads zero
    end
  end

endmodule // eps_port_stats

// file: testbench/eps_stats_assertions.sv
// checker of register-port and interrupt timing for the port statistics block
`timescale 1ns/1ps
`include "eps_stats_consts.vh"
module eps_stats_assertions (
  input wire core_clk,
  input wire rstn,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  input wire [31:0] regRdData,
  input wire rxDone,
  input wire txDone,
  input wire irqOut,
  input wire counterHalfScaleIrq
);
  // ------------------------------
  // recent writes and frames
  // ------------------------------
  reg [3:0] wrHist = 4'h0; // bit k: write k+1 edges back
  reg [3:0] frHist = 4'h0; // bit k: frame done k+1 edges back
  wire recent = (|wrHist[2:0]) | (|frHist[3:1]); // only cause of a move
  // shift the event history
  always @(posedge core_clk)
  begin
    wrHist <= {wrHist[2:0], regWrStb};
    frHist <= {frHist[2:0], rxDone | txDone};
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // ------------------------------
  // properties
  // ------------------------------
  property p_rd_idle;
    !$past(regRdStb) |-> regRdData == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_unmapped;
    regRdStb && regAddr > `EPS_ADDR_LEVEL |=> regRdData == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_resv;
    regRdStb && regAddr == `EPS_ADDR_IRQ_STATUS |=> regRdData[31:3] == 29'h0000_0000;
  endproperty
  a_resv: assert property (p_resv) else $error("status spare bits set");
  property p_follow;
    counterHalfScaleIrq |-> irqOut || $past(irqOut);
  endproperty
  a_follow: assert property (p_follow) else $error("interrupt line low");
  property p_quiet;
    $changed(counterHalfScaleIrq) |-> recent;
  endproperty
  a_quiet: assert property (p_quiet) else $error("half-scale moved alone");
  property p_rise;
    $rose(irqOut) |-> recent;
  endproperty
  a_rise: assert property (p_rise) else $error("interrupt rose alone");
  property p_lvl;
    regRdStb && (regAddr == `EPS_ADDR_LEVEL || regAddr == `EPS_ADDR_IRQ_STATUS) ##1 counterHalfScaleIrq
      |-> regRdData[0];
  endproperty
  a_lvl: assert property (p_lvl) else $error("level bit reads low");
  property p_mask_off;
    regWrStb && regAddr == `EPS_ADDR_IRQ_MASK && regWrData == 32'h0000_0000 |=> !irqOut ##1 !counterHalfScaleIrq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked interrupt high");
endmodule // eps_stats_assertions
bind eps_port_stats eps_stats_assertions eps_stats_assertions_i (
  .core_clk, .rstn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
  .rxDone, .txDone, .irqOut, .counterHalfScaleIrq
);

// file: testbench/eps_mac_model.sv
// behavioural mac frame-status source for the statistics block
`timescale 1ns/1ps
module eps_mac_model (
  input wire core_clk,
  output reg rxDone = 1'b0,
  output reg [15:0] rxLen = 16'h0000,
  output reg [47:0] rxDestAddr = 48'h0000_0000_0000,
  output reg [15:0] rxTypeField = 16'h0000,
  output reg [15:0] rxOpcode = 16'h0000,
  output reg [3:0] rxFlags = 4'h0,
  output reg rxCollFlowFrag = 1'b0,
  output reg phyReceiveError = 1'b0,
  output reg phyRxActive = 1'b0,
  output reg txDone = 1'b0,
  output reg [47:0] txDestAddr = 48'h0000_0000_0000,
  output reg [3:0] txErr = 4'h0
);
  // one received frame; f = {match, control, odd, fcs fail, code err, coll frag}
  task rx(input [15:0] len, input [47:0] da, input [31:0] tyop, input [5:0] f);
    begin
      @(posedge core_clk);
      phyRxActive <= 1'b1;
      phyReceiveError <= f[1];
      // two samples needed so the agreeing sampler stages accept it
      repeat (2) @(posedge core_clk);
      phyReceiveError <= 1'b0;
      repeat (3) @(posedge core_clk);
      {rxLen, rxDestAddr, rxTypeField, rxOpcode, rxFlags} <= {len, da, tyop, f[5:2]};
      rxCollFlowFrag <= f[0];
      rxDone <= 1'b1;
      @(posedge core_clk);
      rxDone <= 1'b0;
      phyRxActive <= 1'b0;
      // released status lines show the inverse
      {rxLen, rxDestAddr, rxTypeField, rxOpcode, rxFlags} <= ~{len, da, tyop, f[5:2]};
      @(posedge core_clk);
    end
  endtask
  // one transmitted frame; e = {late, excess, carrier, underrun}
  task tx(input [47:0] da, input [3:0] e);
    begin
      @(posedge core_clk);
      {txDestAddr, txErr} <= {da, e};
      txDone <= 1'b1;
      @(posedge core_clk);
      txDone <= 1'b0;
      {txDestAddr, txErr} <= ~{da, e};
      @(posedge core_clk);
    end
  endtask
endmodule // eps_mac_model

// file: testbench/eps_port_stats_tb_top.sv
// self-checking bench for the port statistics block
`timescale 1ns/1ps
`include "eps_stats_consts.vh"
module eps_port_stats_tb_top;
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] regAddr = 8'h00;
  reg [31:0] regWrData = 32'h0000_0000;
  reg regWrStb = 1'b0;
  reg regRdStb = 1'b0;
  wire [31:0] regRdData;
  wire irqOut, counterHalfScaleIrq, rxDone, rxCollFlowFrag, phyReceiveError, phyRxActive, txDone;
  wire [15:0] rxLen, rxTypeField, rxOpcode;
  wire [47:0] rxDestAddr, txDestAddr;
  wire [3:0] rxFlags, txErr;
  reg [31:0] expCnt [0:13]; // expected counters
  reg [7:0] a;
  reg flowEn = 1'b0;
  reg clkEn = 1'b1; // freeze control of the block
  integer errCount = 0;
  integer checked = 0;
  integer cycles = 0;
  integer n;
  localparam [47:0] UNI = 48'h0000_0000_0001;
  localparam [47:0] BC = 48'hFFFF_FFFF_FFFF;
  localparam [47:0] MC = 48'h0100_0000_0001;
  localparam [31:0] PAU = 32'h8808_0001;
  eps_mac_model eps_mac_model_i (.core_clk, .rxDone, .rxLen, .rxDestAddr, .rxTypeField, .rxOpcode,
    .rxFlags, .rxCollFlowFrag, .phyReceiveError, .phyRxActive, .txDone, .txDestAddr, .txErr);
  eps_port_stats eps_port_stats_i (.core_clk, .rstn, .clkEn, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .rxDone, .rxLen, .rxDestAddr, .rxTypeField, .rxOpcode,
    .rxAddrMatch(rxFlags[3]), .rxIsControl(rxFlags[2]), .rxOddNibbles(rxFlags[1]), .rxFcsFail(rxFlags[0]),
    .rxCollFlowFrag, .phyReceiveError, .phyRxActive, .txDone, .txDestAddr, .txLateColl(txErr[3]),
    .txExcessColl(txErr[2]), .txCarrierLoss(txErr[1]), .txUnderrun(txErr[0]), .irqOut, .counterHalfScaleIrq);
  // clock and hang guard
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      errCount = errCount + 1;
      final_report;
    end
  end
  // compare and count
  task chk(input string nm, input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        errCount = errCount + 1;
        $display("wrong value %s at %h: expected %h, seen %h", nm, regAddr, e, g);
      end
    end
  endtask
  task wr(input [7:0] ad, input [31:0] d);
    begin
      @(posedge core_clk);
      regAddr <= ad;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge core_clk);
      regWrStb <= 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [31:0] e);
    begin
      @(posedge core_clk);
      regAddr <= ad;
      regRdStb <= 1'b1;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      #1 chk("read data", regRdData, e);
    end
  endtask
  // e: expected half-scale level, l: expected interrupt line
  task irq(input e, input l);
    begin
      repeat (3) @(posedge core_clk);
      #1 chk("half-scale", {31'h0000_0000, counterHalfScaleIrq}, {31'h0000_0000, e});
      chk("irq line", {31'h0000_0000, irqOut}, {31'h0000_0000, l});
    end
  endtask
  // frame and its expected counter effects
  task rxf(input [15:0] len, input [47:0] da, input [31:0] tyop, input [5:0] f);
    reg err, ok, gd, big, sh;
    begin
      eps_mac_model_i.rx(len, da, tyop, f);
      err = f[2] | f[1];
      ok = len >= `EPS_MIN_FRAME_LEN && len <= 16'h05EE;
      big = len > 16'h05EE;
      sh = len < `EPS_MIN_FRAME_LEN && !f[4];
      gd = f[5] & ok & !err;
      expCnt[0] = expCnt[0] + gd;
      expCnt[1] = expCnt[1] + (gd & (&da));
      expCnt[2] = expCnt[2] + (gd & da[40] & ~&da);
      expCnt[3] = expCnt[3] + (ok & !err & flowEn & tyop == PAU);
      expCnt[4] = expCnt[4] + (f[5] & ok & f[2] & !f[3] & !f[1]);
      expCnt[5] = expCnt[5] + (f[5] & ok & (f[2] & f[3] | f[1]));
      expCnt[6] = expCnt[6] + (f[5] & big & !err);
      expCnt[7] = expCnt[7] + (f[5] & big & err);
      expCnt[8] = expCnt[8] + (f[5] & sh & !err);
      expCnt[9] = expCnt[9] + (sh & err & !f[0]);
      expCnt[10] = expCnt[10] + (gd ? len : 16'h0000);
    end
  endtask
  task txf(input [47:0] da, input [3:0] e);
    begin
      eps_mac_model_i.tx(da, e);
      expCnt[11] = expCnt[11] + (~|e);
      expCnt[12] = expCnt[12] + (~|e & (&da));
      expCnt[13] = expCnt[13] + (~|e & da[40] & ~&da);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d, mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // main sequence
  initial
  begin
    for (n = 0; n < 14; n = n + 1)
      expCnt[n] = 32'h0000_0000;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    rd(`EPS_ADDR_CONTROL, `EPS_CTL_RESET);
    rd(`EPS_ADDR_IRQ_MASK, 32'h0000_0000);
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0000_0000);
    $display("test reset and map done");
    rxf(16'h0040, UNI, 0, 6'b100000);
    rxf(16'h05EE, BC, 0, 6'b100000);
    rxf(16'h0064, MC, 0, 6'b110000);
    rxf(16'h0040, MC, PAU, 6'b000000);
    wr(`EPS_ADDR_CONTROL, 32'h05EE_0001);
    flowEn = 1'b1;
    for (n = 0; n < 2; n = n + 1)
      rxf(16'h0040, UNI, PAU, {n[0], 5'b00000});
    rxf(16'h0040, UNI, 0, 6'b100100);
    rxf(16'h0041, UNI, 0, 6'b101100);
    rxf(16'h00C8, UNI, 0, 6'b100010);
    rxf(16'h0041, UNI, 0, 6'b101000);
    rxf(16'h05EF, UNI, 0, 6'b100000);
    rxf(16'h05EF, UNI, 0, 6'b100100);
    rxf(16'h003F, UNI, 0, 6'b100000);
    rxf(16'h003F, UNI, 0, 6'b110100);
    rxf(16'h003F, UNI, 0, 6'b000100);
    rxf(16'h003F, UNI, 0, 6'b000101);
    for (n = 0; n < 5; n = n + 1)
      txf(UNI, 4'b1000 >> n);
    txf(MC, 4'b0000);
    fork
      rxf(16'h05EE, BC, 0, 6'b100000);
      txf(BC, 4'b0000);
    join
    txf(BC, 4'b0001);
    for (a = 8'h00; a < 8'h38; a = a + 8'h04)
      rd(a, expCnt[a[5:2]]);
    $display("test frame classes done");
    rd(`EPS_ADDR_IRQ_STATUS, 32'h0000_0006);
    wr(`EPS_ADDR_IRQ_MASK, 32'h0000_0004);
    irq(1'b0, 1'b1);
    chk("done irq", {31'h0000_0000, irqOut}, 32'h0000_0001);
    wr(`EPS_ADDR_IRQ_MASK, 32'h0000_0000);
    wr(`EPS_ADDR_IRQ_STATUS, 32'h0000_0006);
    rd(`EPS_ADDR_IRQ_STATUS, 32'h0000_0000);
    wr(`EPS_ADDR_IRQ_MASK, 32'h0000_0001);
    wr(8'h10, expCnt[4] + 32'h0000_0001);
    irq(1'b1, 1'b1);
    rd(`EPS_ADDR_LEVEL, 32'h0000_0001);
    rd(8'h10, 32'hFFFF_FFFF);
    rxf(16'h0040, UNI, 0, 6'b100100);
    irq(1'b0, 1'b0);
    rd(8'h10, 32'h0000_0000);
    wr(8'h00, expCnt[0] - 32'h8000_0000);
    irq(1'b1, 1'b1);
    wr(8'h00, 32'h0000_0001);
    irq(1'b0, 1'b0);
    // a write while the clock enable is low must be lost
    clkEn <= 1'b0;
    wr(8'h00, 32'h0000_0001);
    clkEn <= 1'b1;
    rd(8'h00, 32'h7FFF_FFFF);
    $display("test half scale done");
    final_report;
  end
endmodule // eps_port_stats_tb_top
